/* dllcg_div.sv */
module dllcg_div
    import dllcg_pkg::*;
#(
    parameter int unsigned PW = DLLCG_PER_W
) (
    // clock and reset
    input  wire logic          clk_i,
    input  wire logic          sys_rst_i,
    // control
    input  wire logic          clr_i,
    input  wire logic          edge_i,
    input  wire logic [PW-1:0] per_i,
    input  wire logic [2:0]    sel_i,
    // output
    output logic               div_o
);
    logic [5:0]    n2;
    logic [PW+5:0] half;
    logic [PW+5:0] cnt_q;
    logic [5:0]    nedge_q;

    always_comb begin
        case (sel_i)
            DLLCG_DIV_1P5: n2 = 6'h03;
            DLLCG_DIV_2:   n2 = 6'h04;
            DLLCG_DIV_2P5: n2 = 6'h05;
            DLLCG_DIV_3:   n2 = 6'h06;
            DLLCG_DIV_4:   n2 = 6'h08;
            DLLCG_DIV_5:   n2 = 6'h0A;
            DLLCG_DIV_8:   n2 = 6'h10;
            default:       n2 = 6'h20;
        endcase
    end

    // half output period = N*P/2 cycles: equal halves give 50/50
    assign half = (PW+6)'(({6'h00, per_i} * {{PW{1'b0}}, n2}) >> 2); // [RQ14] [RQ15]

    // realign to a source edge each whole output period for integer ratios only;
    // fractional ratios are never realigned and run on the counter alone
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_q   <= '0;
            div_o   <= 1'b0;
            nedge_q <= '0;
        end else if (clr_i) begin
            cnt_q   <= '0;
            div_o   <= 1'b0;
            nedge_q <= '0;
        end else if (edge_i && nedge_q == 6'(n2 >> 1) - 6'h01 && !n2[0]) begin
            cnt_q   <= '0;
            div_o   <= 1'b1;
            nedge_q <= '0;
        end else begin
            if (edge_i) begin
                nedge_q <= nedge_q + 6'h01;
            end
            if (half != '0 && cnt_q >= half - 1'b1) begin
                cnt_q <= '0;
                div_o <= ~div_o; // [RQ15]
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end
endmodule

/* dllcg_if.sv */
interface dllcg_if;
    import dllcg_pkg::*;
    logic src;
    logic fb;
    logic loop_rst;
    logic unity;
    logic doubled;
    logic divided;
    logic locked;

    modport dev (
        input  src,
        input  fb,
        input  loop_rst,
        output unity,
        output doubled,
        output divided,
        output locked
    );

    modport net (
        output src,
        output fb,
        output loop_rst,
        input  unity,
        input  doubled,
        input  divided,
        input  locked
    );
endinterface

/* dllcg_loop.sv */
module dllcg_loop
    import dllcg_pkg::*;
#(
    parameter bit          SIMPLE    = 1'b0,
    parameter bit          HF_VAR    = 1'b0,
    parameter bit          HOLD_CFG  = 1'b1,
    parameter int unsigned PW        = DLLCG_PER_W
) (
    // clock and reset
    input  wire logic      clk_i,
    input  wire logic      sys_rst_i,
    // link to clock network
    dllcg_if.dev           lnk,
    // user side
    input  wire logic      dcc_en_i,
    input  wire logic [2:0] div_sel_i,
    output logic           cfg_done_o,
    output logic [DLLCG_TAP_W-1:0] tap_o
);
    // ************************************************
    // source period measurement
    // ************************************************
    logic          src_q;
    logic          src_rise;
    logic [PW-1:0] pcnt_q;
    logic [PW-1:0] per_q;
    logic          rst_eff;

    // the simple macro has no reset pin
    assign rst_eff  = SIMPLE ? 1'b0 : lnk.loop_rst; // [RQ3] [RQ8]
    assign src_rise = lnk.src & ~src_q;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            src_q  <= 1'b0;
            pcnt_q <= '0;
            per_q  <= '0;
        end else begin
            src_q <= lnk.src;
            if (src_rise) begin
                pcnt_q <= '0;
                per_q  <= pcnt_q + 1'b1;
            end else if (pcnt_q != '1) begin
                pcnt_q <= pcnt_q + 1'b1;
            end
        end
    end

    // ************************************************
    // delay tap line
    // ************************************************
    logic [DLLCG_TAPS-1:0]  line_q;
    logic [DLLCG_TAP_W-1:0] tap_q;
    logic                   dl_raw;
    logic                   dl_q;
    logic                   dl_rise;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            line_q <= '0;
            dl_q   <= 1'b0;
        end else begin
            line_q <= {line_q[DLLCG_TAPS-2:0], lnk.src};
            dl_q   <= dl_raw;
        end
    end

    assign dl_raw  = line_q[tap_q]; // [RQ1]
    assign dl_rise = dl_raw & ~dl_q;

    // ************************************************
    // phase detector and lock
    // ************************************************
    dllcg_lock_e                      lk_q;
    logic                             fb_q;
    logic                             fb_rise;
    logic                             fb_seen_q;
    logic [$clog2(DLLCG_LOCK_EDGES):0] good_q;
    logic                             aligned;

    assign fb_rise = lnk.fb & ~fb_q;
    // a feedback edge in the same cycle or one cycle earlier counts as aligned:
    // the sampled loop cannot resolve finer than one cycle
    assign aligned = src_rise & (fb_rise | fb_seen_q);

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            fb_q      <= 1'b0;
            fb_seen_q <= 1'b0;
        end else begin
            fb_q      <= lnk.fb;
            fb_seen_q <= fb_rise;
        end
    end

    // tap search: each misaligned source edge in DLLCG_SEARCH steps one tap later, or back to DLLCG_TAP_RST from the last tap or a tap of per_q or above
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tap_q <= DLLCG_TAP_RST;
        end else if (rst_eff) begin
            tap_q <= DLLCG_TAP_RST; // [RQ9]
        end else if (src_rise && !aligned && lk_q == DLLCG_SEARCH) begin
            if (tap_q == DLLCG_TAP_W'(DLLCG_TAPS - 1) ||
                    {2'b00, tap_q} >= per_q) begin
                tap_q <= DLLCG_TAP_RST;
            end else begin
                tap_q <= tap_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            lk_q   <= DLLCG_SEARCH;
            good_q <= '0;
        end else if (rst_eff) begin
            lk_q   <= DLLCG_SEARCH; // [RQ7]
            good_q <= '0;
        end else if (src_rise) begin
            case (lk_q)
                DLLCG_SEARCH: begin
                    if (!aligned) begin
                        good_q <= '0;
                    end else if (good_q == DLLCG_LOCK_EDGES - 1) begin
                        lk_q <= DLLCG_LOCKED; // [RQ17]
                    end else begin
                        good_q <= good_q + 1'b1;
                    end
                end
                DLLCG_LOCKED: begin
                    if (!aligned) begin
                        lk_q   <= DLLCG_SEARCH; // [RQ17]
                        good_q <= '0;
                    end
                end
                default: lk_q <= DLLCG_SEARCH;
            endcase
        end
    end

    // ************************************************
    // output shaping
    // ************************************************
    logic [PW-1:0] ph_q;
    logic [PW-1:0] hp;
    logic [PW-1:0] qp;
    logic [PW-1:0] ph_h;
    logic          unity_d;
    logic          dbl_d;
    logic          locked;

    assign locked = (lk_q == DLLCG_LOCKED);
    assign hp     = per_q >> 1;
    assign qp     = per_q >> 2;
    // phase counted from the delayed edge itself, so both pulses of
    // the doubled clock get a full quarter period
    assign ph_h   = (ph_q >= hp - 1'b1) ? ph_q - (hp - 1'b1) : ph_q + 1'b1;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ph_q <= '0;
        end else if (dl_rise) begin
            ph_q <= '0;
        end else if (ph_q != '1) begin
            ph_q <= ph_q + 1'b1;
        end
    end

    always_comb begin
        // phase restarts on each delayed source edge
        unity_d = dcc_en_i ? (dl_rise | (ph_q < hp - 1'b1)) : dl_raw; // [RQ2] [RQ18]
        if (SIMPLE || HF_VAR) begin
            dbl_d = 1'b0; // [RQ3] [RQ13]
        end else if (locked) begin
            dbl_d = dl_rise | (ph_h < qp); // [RQ11]
        end else begin
            dbl_d = dl_rise | (ph_q < qp - 1'b1); // [RQ12]
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            lnk.unity   <= 1'b0;
            lnk.doubled <= 1'b0;
            lnk.locked  <= 1'b0;
            cfg_done_o  <= 1'b0;
            tap_o       <= DLLCG_TAP_RST;
        end else begin
            lnk.unity   <= unity_d; // [RQ1]
            lnk.doubled <= dbl_d;
            lnk.locked  <= SIMPLE ? 1'b0 : locked; // [RQ3]
            cfg_done_o  <= HOLD_CFG ? locked : 1'b1; // [RQ16]
            tap_o       <= tap_q;
        end
    end

    // ************************************************
    // divided output
    // ************************************************
    logic div_q;

    dllcg_div #(
        .PW (PW)
    ) u_div (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .clr_i     (rst_eff | SIMPLE),
        .edge_i    (dl_rise),
        .per_i     (per_q),
        .sel_i     (div_sel_i),
        .div_o     (div_q)
    );

    assign lnk.divided = div_q; // [RQ14] [RQ3]
endmodule

/* dllcg_net.sv */
module dllcg_net
    import dllcg_pkg::*;
#(
    parameter bit          FB_DOUBLED = 1'b0,
    parameter int unsigned NET_DLY    = DLLCG_NET_DLY
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    // link to loop
    dllcg_if.net      lnk,
    // board and user side
    input  wire logic src_pin_i,
    input  wire logic user_rst_i,
    output logic      gclk_unity_o,
    output logic      gclk_dbl_o,
    output logic      gclk_div_o,
    output logic      locked_o
);
    logic [DLLCG_SYNC-1:0] sync_q;
    logic [NET_DLY-1:0]    u_dly_q;
    logic [NET_DLY-1:0]    d_dly_q;
    logic [4:0]            rcnt_q;

    // source enters through the input buffer, synchronised
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sync_q  <= '0;
            lnk.src <= 1'b0;
        end else begin
            sync_q  <= {sync_q[DLLCG_SYNC-2:0], src_pin_i};
            lnk.src <= sync_q[DLLCG_SYNC-1]; // [RQ4]
        end
    end

    // global buffer latency, compensated by the loop
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            u_dly_q <= '0;
            d_dly_q <= '0;
            lnk.fb  <= 1'b0;
        end else begin
            u_dly_q <= {u_dly_q[NET_DLY-2:0], lnk.unity};
            d_dly_q <= {d_dly_q[NET_DLY-2:0], lnk.doubled};
            lnk.fb  <= FB_DOUBLED ? d_dly_q[NET_DLY-1] : u_dly_q[NET_DLY-1]; // [RQ5] [RQ6]
        end
    end

    // reset is always driven; a request is stretched
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rcnt_q       <= '0;
            lnk.loop_rst <= 1'b1;
        end else if (user_rst_i) begin
            rcnt_q       <= 5'(DLLCG_RST_HOLD - 1);
            lnk.loop_rst <= 1'b1; // [RQ10] [RQ8]
        end else if (rcnt_q != '0) begin
            rcnt_q       <= rcnt_q - 5'h01;
            lnk.loop_rst <= 1'b1;
        end else begin
            lnk.loop_rst <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            gclk_unity_o <= 1'b0;
            gclk_dbl_o   <= 1'b0;
            gclk_div_o   <= 1'b0;
            locked_o     <= 1'b0;
        end else begin
            gclk_unity_o <= u_dly_q[NET_DLY-1];
            gclk_dbl_o   <= d_dly_q[NET_DLY-1];
            gclk_div_o   <= lnk.divided;
            locked_o     <= lnk.locked;
        end
    end
endmodule

/* dllcg_pkg.sv */
// What this block does
// [RQ1] simple macro outputs deskewed source copy
// [RQ2] unity output 50/50 unless correction off
// [RQ3] simple macro hides reset, lock, mult, div
// [RQ4] source clock from same-edge input buffer only
// [RQ5] feedback only from unity or doubled output
// [RQ6] external feedback uses doubled, drives pads only
// [RQ7] lock drops within four source cycles of reset
// [RQ8] reset active high, driven, never floating
// [RQ9] reset zeroes taps; outputs may glitch
// [RQ10] reset loop after frequency or setup change
// [RQ11] locked doubled output: 2x, 50/50
// [RQ12] unlocked doubled output: 1x, 25/75
// [RQ13] high-frequency variant has no doubled output
// [RQ14] divided output divides by configured ratio
// [RQ15] divided output 50/50 for every ratio
// [RQ16] optionally hold configuration done until lock
// [RQ17] lock only while feedback aligns source
// [RQ18] unity output source-rate, aligned when locked
package dllcg_pkg;
    // ************************************************
    // widths and counts
    // ************************************************
    localparam int unsigned DLLCG_PER_W     = 8;
    localparam int unsigned DLLCG_TAP_W     = 6;
    localparam int unsigned DLLCG_TAPS      = 64;
    localparam int unsigned DLLCG_LOCK_EDGES = 8;
    localparam int unsigned DLLCG_SYNC      = 2;
    localparam int unsigned DLLCG_NET_DLY   = 5;
    localparam int unsigned DLLCG_RST_HOLD  = 16;
    localparam int unsigned DLLCG_LOCK_MAX_SRC = 4;
    localparam logic [DLLCG_TAP_W-1:0] DLLCG_TAP_RST = 6'h00;

    // ************************************************
    // divide ratio codes, ratio held as 2*N
    // ************************************************
    localparam logic [2:0] DLLCG_DIV_1P5 = 3'h0;
    localparam logic [2:0] DLLCG_DIV_2   = 3'h1;
    localparam logic [2:0] DLLCG_DIV_2P5 = 3'h2;
    localparam logic [2:0] DLLCG_DIV_3   = 3'h3;
    localparam logic [2:0] DLLCG_DIV_4   = 3'h4;
    localparam logic [2:0] DLLCG_DIV_5   = 3'h5;
    localparam logic [2:0] DLLCG_DIV_8   = 3'h6;
    localparam logic [2:0] DLLCG_DIV_16  = 3'h7;
    localparam logic [2:0] DLLCG_DIV_RST = 3'h1;

    typedef enum logic {DLLCG_SEARCH, DLLCG_LOCKED} dllcg_lock_e;
endpackage

/* dllcg_properties.sv */
module dllcg_properties
    import dllcg_pkg::*;
#(
    parameter int SRC_PER = 16
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    // link between loop and clock network
    input  wire logic src,
    input  wire logic fb,
    input  wire logic loop_rst,
    input  wire logic unity,
    input  wire logic doubled,
    input  wire logic divided,
    input  wire logic locked
);
    timeunit 1ns;
    timeprecision 1ps;

    // taps may add one cycle to a period while searching
    localparam int UNI_MAX = SRC_PER + 2;
    localparam int QUART   = SRC_PER / 4;
    localparam int DIV_MAX = SRC_PER * 8;

    logic       src_q;
    logic       rise;
    logic [4:0] rise_cnt_q;

    // ************************************************
    // source rise counter since the last loop reset
    // ************************************************
    assign rise = src && !src_q;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i)
            src_q <= 1'h0;
        else
            src_q <= src;
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i)
            rise_cnt_q <= 5'h00;
        else if (loop_rst)
            rise_cnt_q <= 5'h00;
        else if (rise && rise_cnt_q != 5'h1F)
            rise_cnt_q <= rise_cnt_q + 5'h01;
    end

    // ************************************************
    // properties
    // ************************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);

    // the lock state and the lock output are one register apart
    chk_lock_drop: assert property (loop_rst |-> ##2 !locked)
        else $error("lock still high after loop reset");
    chk_lock_settle: assert property ($rose(locked) |-> rise_cnt_q >= DLLCG_LOCK_EDGES)
        else $error("lock rose before enough source edges");
    chk_lock_stay: assert property ($fell(locked) |->
        $past(loop_rst) || $past(loop_rst, 2) || $past(rise) || $past(rise, 2) || $past(rise, 3))
        else $error("lock fell without reset or source edge");
    chk_unity_duty: assert property ($rose(unity) && !loop_rst |->
        (unity || loop_rst)[*8] ##1 (!unity || loop_rst))
        else $error("unity high time not half a period");
    chk_unity_rate: assert property ($rose(src) && !loop_rst |->
        ##[1:UNI_MAX] ($rose(unity) || loop_rst))
        else $error("unity missing a rise within a source period");
    chk_dbl_locked: assert property (locked && $fell(doubled) |-> ##[1:QUART] (doubled || !locked))
        else $error("locked doubled clock low too long");
    chk_dbl_search: assert property (!locked && !loop_rst && $fell(doubled) |->
        (!doubled || locked || loop_rst)[*8])
        else $error("unlocked doubled clock toggles too fast");
    chk_div_alive: assert property (locked && $changed(divided) |->
        ##[1:DIV_MAX] ($changed(divided) || !locked))
        else $error("divided clock stalled");
endmodule

/* dllcg_tb.sv */
module testbench
    import dllcg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int SRC_PER = 16;
    localparam int LIMIT   = 40000;

    logic                   clk_i;
    logic                   sys_rst_i;
    logic                   src_pin_i;
    logic                   user_rst_i;
    logic                   dcc_en_i;
    logic [2:0]             div_sel_i;
    logic [2:0]             g_unity;
    logic [2:0]             g_dbl;
    logic [2:0]             g_div;
    logic [2:0]             g_lock;
    logic [2:0]             g_cfg;
    logic [DLLCG_TAP_W-1:0] g_tap [3];
    logic [11:0]            obs;
    int                     src_cnt;
    int                     cycles;
    int                     miscompares;
    int                     n_compared;
    int                     twice_n [8] = '{3, 4, 5, 6, 8, 10, 16, 32};

    assign obs = {g_lock, g_div, g_dbl, g_unity};

    // ************************************************
    // instance 0 full loop, 1 simple macro, 2 fast variant without config hold
    // ************************************************
    for (genvar g = 0; g < 3; g++) begin : g_dut
        dllcg_if lnk ();
        dllcg_loop #(.SIMPLE(g == 1), .HF_VAR(g == 2), .HOLD_CFG(g != 2)) dllcg_loop_inst (
            .clk_i(clk_i), .sys_rst_i(sys_rst_i), .lnk(lnk), .dcc_en_i(dcc_en_i),
            .div_sel_i(div_sel_i), .cfg_done_o(g_cfg[g]), .tap_o(g_tap[g]));
        dllcg_net dllcg_net_inst (
            .clk_i(clk_i), .sys_rst_i(sys_rst_i), .lnk(lnk), .src_pin_i(src_pin_i),
            .user_rst_i(user_rst_i), .gclk_unity_o(g_unity[g]), .gclk_dbl_o(g_dbl[g]),
            .gclk_div_o(g_div[g]), .locked_o(g_lock[g]));
        if (g == 0) begin : g_chk
            dllcg_properties #(.SRC_PER(SRC_PER)) dllcg_properties_inst (
                .clk_i(clk_i), .sys_rst_i(sys_rst_i), .src(lnk.src), .fb(lnk.fb),
                .loop_rst(lnk.loop_rst), .unity(lnk.unity), .doubled(lnk.doubled),
                .divided(lnk.divided), .locked(lnk.locked));
        end
    end

    initial begin
        clk_i = 1'h0;
        forever #10 clk_i = ~clk_i;
    end

    // board source clock, 50/50, SRC_PER cycles
    always @(posedge clk_i) begin
        src_cnt <= (src_cnt + 1) % SRC_PER;
        src_pin_i <= (src_cnt < SRC_PER / 2);
    end

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            miscompares++;
            give_verdict();
        end
    end

    // ************************************************
    // tasks
    // ************************************************
    task automatic tick();
        @(posedge clk_i);
        #1;
    endtask

    task automatic check_bit(input logic got, input logic exp, input string what);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic check_num(input int got, input int exp, input string what);
        n_compared++;
        if (got != exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s got %0d expected %0d", $time, what, got, exp);
        end
    endtask

    task automatic wait_lvl(input int b, input logic lvl, output int n);
        n = 0;
        while (obs[b] !== lvl && n < 3000) begin
            tick();
            n++;
        end
    endtask

    task automatic measure(input int b, output int hi, output int per);
        int lo;
        wait_lvl(b, 1'h0, lo);
        wait_lvl(b, 1'h1, lo);
        wait_lvl(b, 1'h0, hi);
        wait_lvl(b, 1'h1, lo);
        per = hi + lo;
    endtask

    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ************************************************
    // main sequence
    // ************************************************
    initial begin
        int   hi;
        int   per;
        int   n;
        logic seen;
        logic hf;
        logic [DLLCG_TAP_W-1:0] tap_prev;
        sys_rst_i = 1'h1;
        src_pin_i = 1'h0;
        user_rst_i = 1'h0;
        dcc_en_i = 1'h1;
        div_sel_i = DLLCG_DIV_RST;
        src_cnt = 0;
        cycles = 0;
        miscompares = 0;
        n_compared = 0;
        repeat (20) @(posedge clk_i);
        sys_rst_i <= 1'h0;
        tick();
        check_bit(g_lock[0], 1'h0, "lock after reset");
        check_bit(g_cfg[0], 1'h0, "config done after reset");
        check_bit(g_cfg[2], 1'h1, "config done without hold");
        // every ratio is set before a loop reset, as a setup change demands
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_i);
            div_sel_i <= 3'(i);
            @(posedge clk_i);
            user_rst_i <= 1'h1;
            @(posedge clk_i);
            user_rst_i <= 1'h0;
            tick();
            wait_lvl(9, 1'h0, n);
            check_bit(n <= 4 * SRC_PER, 1'h1, "lock drop time");
            check_bit(g_tap[0] === DLLCG_TAP_RST, 1'h1, "taps cleared");
            if (i > 0) begin
                check_bit(g_tap[1] !== DLLCG_TAP_RST, 1'h1, "simple macro ignores reset");
            end
            n = 0;
            while (g_dut[0].lnk.loop_rst !== 1'h0 && n < 100) begin
                tick();
                n++;
            end
            // each search step moves the delayed edge a cycle later, so the
            // 1x period is only clean once the tap has settled
            n = 0;
            while (n < SRC_PER + 2) begin
                tap_prev = g_tap[0];
                tick();
                n = (g_tap[0] === tap_prev) ? n + 1 : 0;
            end
            measure(3, hi, per);
            check_num(per, SRC_PER, "unlocked doubled period");
            check_num(hi, SRC_PER / 4, "unlocked doubled high");
            wait_lvl(9, 1'h1, n);
            check_bit(g_lock[0], 1'h1, "lock reached");
            check_bit(g_cfg[0], 1'h1, "config done with lock");
            measure(6, hi, per);
            check_num(per, twice_n[i] * SRC_PER / 2, "divided period");
            check_num(hi, twice_n[i] * SRC_PER / 4, "divided high");
            measure(0, hi, per);
            check_num(per, SRC_PER, "unity period");
            check_num(hi, SRC_PER / 2, "unity high");
            measure(3, hi, per);
            check_num(per, SRC_PER / 2, "locked doubled period");
            check_num(hi, SRC_PER / 4, "locked doubled high");
        end
        wait_lvl(11, 1'h1, n);
        check_bit(g_lock[2], 1'h1, "fast variant lock");
        seen = 1'h0;
        hf = 1'h0;
        repeat (4 * SRC_PER) begin
            tick();
            seen = seen | g_lock[1] | g_dbl[1] | g_div[1];
            hf = hf | g_dbl[2];
        end
        check_bit(seen, 1'h0, "simple macro extra outputs");
        check_bit(hf, 1'h0, "fast variant doubled");
        measure(1, hi, per);
        check_num(per, SRC_PER, "simple macro period");
        check_num(hi, SRC_PER / 2, "simple macro high");
        @(posedge clk_i);
        dcc_en_i <= 1'h0;
        measure(0, hi, per);
        check_num(per, SRC_PER, "raw unity period");
        check_num(hi, SRC_PER / 2, "raw unity high");
        give_verdict();
    end
endmodule
